/* File: core/wdt_mode_pkg.sv */
// constants, types and register map of the watchdog mode control block
// Contract
// - mode register takes one write after reset, before the first trigger
// - a written mode takes effect only at the next watchdog trigger
// - a differing mode write after start raises a watchdog error
// - an identical mode write after start is accepted without error
// - mode register is reached by byte-wide accesses only
// - bits 6..4 pick an overflow interval of 2^9..2^16 count clocks
// - bit 2 picks error response: 0 interrupt request, 1 reset
// - bits 1..0 pick open window of 25, 50, 75 or 100 percent
package wdt_mode_pkg;

   // register byte addresses on the 32-bit bus
   localparam logic [31:0] MODE_ADDR   = 32'h4000_070C;
   localparam logic [31:0] STATUS_ADDR = 32'h4000_0710;
   localparam logic [31:0] MASK_ADDR   = 32'h4000_0714;
   localparam logic [31:0] STATE_ADDR  = 32'h4000_0718;

   // reset values
   localparam logic [7:0] MODE_RESET   = 8'h0F;
   localparam logic [2:0] MASK_RESET   = 3'h0;
   localparam logic [2:0] STATUS_RESET = 3'h0;

   // status and mask bit positions
   localparam int unsigned ST_MODE_ERR = 0;
   localparam int unsigned ST_OVF_ERR  = 1;
   localparam int unsigned ST_TRIGGER  = 2;
   localparam int unsigned STATUS_W    = 3;

   // state register field positions
   localparam int unsigned STATE_PHASE_LSB  = 0;
   localparam int unsigned STATE_ACTIVE_LSB = 8;

   // interval exponent base, count width, byte lane of the mode register
   localparam logic [4:0] OVF_BASE_EXP = 5'h09;
   localparam int unsigned CNT_W       = 17;
   localparam logic [3:0] BYTE0_STRB   = 4'h1;

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // mode register layout, bit 7 down to bit 0
   typedef struct packed {
      logic       rsv7;
      logic [2:0] overflow_interval_select;
      logic       rsv3;
      logic       error_response_select;
      logic [1:0] window_size_select;
   } mode_s;

   // configuration phase, gray coded along open -> set -> run
   typedef enum logic [1:0] {
      ST_OPEN = 2'h0,
      ST_SET  = 2'h1,
      ST_RUN  = 2'h3
   } phase_e;

endpackage

/* File: core/wdt_mode_ctrl.sv */
// watchdog mode register, error routing and axi4-lite slave
`timescale 1ns/10ps
module wdt_mode_ctrl
   import wdt_mode_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [31:0]       awaddr,
   input  wire logic [2:0]        awprot,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [31:0]       araddr,
   input  wire logic [2:0]        arprot,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   input  wire logic              wdt_trigger,
   input  wire logic              wdt_overflow,
   output mode_s                  active_mode,
   output logic [CNT_W-1:0]       interval_count,
   output logic [CNT_W-1:0]       window_count,
   output logic                   nmi_req,
   output logic                   reset_req,
   output logic                   irq
);

   // bus state
   logic                  awready_r;
   logic                  wready_r;
   logic                  bvalid_r;
   logic [1:0]            bresp_r;
   logic                  arready_r;
   logic                  rvalid_r;
   logic [31:0]           rdata_r;
   logic [1:0]            rresp_r;
   logic                  aw_full_r;
   logic                  w_full_r;
   logic [31:0]           waddr_r;
   logic [31:0]           wdata_r;
   logic [3:0]            wstrb_r;

   // block state
   phase_e                phase_r;
   phase_e                phase_nxt;
   mode_s                 mode_r;
   mode_s                 mode_nxt;
   mode_s                 active_r;
   logic [STATUS_W-1:0]   status_r;
   logic [STATUS_W-1:0]   status_nxt;
   logic [STATUS_W-1:0]   mask_r;
   logic [STATUS_W-1:0]   mask_nxt;
   logic [CNT_W-1:0]      interval_r;
   logic [CNT_W-1:0]      window_r;
   logic                  nmi_req_r;
   logic                  reset_req_r;
   logic                  irq_r;

   // write decode
   wire                   aw_hs      = awvalid && awready_r;
   wire                   w_hs       = wvalid && wready_r;
   wire                   do_wr      = aw_full_r && w_full_r && !bvalid_r;
   wire                   hit_mode   = waddr_r == MODE_ADDR;
   wire                   hit_status = waddr_r == STATUS_ADDR;
   wire                   hit_mask   = waddr_r == MASK_ADDR;
   wire                   hit_state  = waddr_r == STATE_ADDR;
   wire                   byte_ok    = wstrb_r == BYTE0_STRB;
   wire                   wr_mode    = do_wr && hit_mode && byte_ok;
   wire                   wr_status  = do_wr && hit_status && wstrb_r[0];
   wire                   wr_mask    = do_wr && hit_mask && wstrb_r[0];
   wire                   wr_bad     = (hit_mode && !byte_ok) || !(hit_mode || hit_status || hit_mask || hit_state);

   // incoming mode byte; reserved bits never take written data
   mode_s                 wr_val;
   assign wr_val = '{rsv7: 1'b0,
                     overflow_interval_select: wdata_r[6:4],
                     rsv3: mode_r.rsv3,
                     error_response_select: wdata_r[2],
                     window_size_select: wdata_r[1:0]};

   // once the single write is used or the watchdog runs, only equal values pass
   wire                   locked     = phase_r != ST_OPEN;
   wire                   differs    = wr_val != mode_r;
   wire                   mode_err   = wr_mode && locked && differs;
   wire                   err_evt    = mode_err || wdt_overflow;

   // read decode
   wire                   ar_hs      = arvalid && arready_r;
   wire                   r_hs       = rvalid_r && rready;
   wire                   rd_mode    = araddr == MODE_ADDR;
   wire                   rd_status  = araddr == STATUS_ADDR;
   wire                   rd_mask    = araddr == MASK_ADDR;
   wire                   rd_state   = araddr == STATE_ADDR;
   wire                   rd_hit     = rd_mode || rd_status || rd_mask || rd_state;
   logic [31:0]           rd_word;
   assign rd_word = rd_mode   ? {24'h0, mode_r} :
                    rd_status ? {{(32-STATUS_W){1'b0}}, status_r} :
                    rd_mask   ? {{(32-STATUS_W){1'b0}}, mask_r} :
                    rd_state  ? {16'h0, active_r, 6'h0, phase_r} :
                    32'h0;

   // overflow interval and open window derived from the applied mode
   wire [4:0]             shamt      = OVF_BASE_EXP + {2'h0, active_r.overflow_interval_select};
   wire [CNT_W-1:0]       interval_w = {{(CNT_W-1){1'b0}}, 1'b1} << shamt;
   wire [CNT_W-1:0]       quarter_w  = interval_w >> 2;
   wire [CNT_W-1:0]       window_w   = CNT_W'(quarter_w * ({1'b0, active_r.window_size_select} + 3'h1));

   // phase and mode register next state
   always_comb begin
      phase_nxt = phase_r;
      mode_nxt  = mode_r;
      if (wr_mode && phase_r == ST_OPEN) begin
         mode_nxt  = wr_val;
         phase_nxt = ST_SET;
      end
      if (wdt_trigger) begin
         phase_nxt = ST_RUN;
      end
   end

   // sticky status: a set in the clearing cycle wins so no event is lost
   assign status_nxt = (status_r & ~(wr_status ? wdata_r[STATUS_W-1:0] : {STATUS_W{1'b0}}))
                       | {wdt_trigger, wdt_overflow, mode_err};
   assign mask_nxt   = wr_mask ? wdata_r[STATUS_W-1:0] : mask_r;

   // write channel capture, addr and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
         aw_full_r <= 1'b0;
         w_full_r  <= 1'b0;
         waddr_r   <= 32'h0;
         wdata_r   <= 32'h0;
         wstrb_r   <= 4'h0;
      end else begin
         awready_r <= !aw_full_r && !aw_hs && !bvalid_r;
         wready_r  <= !w_full_r && !w_hs && !bvalid_r;
         if (aw_hs) begin
            aw_full_r <= 1'b1;
            waddr_r   <= awaddr;
         end else if (do_wr) begin
            aw_full_r <= 1'b0;
         end
         if (w_hs) begin
            w_full_r <= 1'b1;
            wdata_r  <= wdata;
            wstrb_r  <= wstrb;
         end else if (do_wr) begin
            w_full_r <= 1'b0;
         end
      end
   end

   // write response; non-byte mode write or unmapped address answers slverr
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
      end else if (do_wr) begin
         bvalid_r <= 1'b1;
         bresp_r  <= wr_bad ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid_r && bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // read channel; one read at a time, data captured at the address edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h0;
         rresp_r   <= RESP_OKAY;
      end else begin
         arready_r <= !rvalid_r && !ar_hs;
         if (ar_hs) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_word;
            rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (r_hs) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   // mode storage; running config only follows the register at a trigger
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_r  <= ST_OPEN;
         mode_r   <= MODE_RESET;
         active_r <= MODE_RESET;
      end else begin
         phase_r <= phase_nxt;
         mode_r  <= mode_nxt;
         if (wdt_trigger) begin
            active_r <= mode_nxt;
         end
      end
   end

   // status, mask, interrupt and error responses
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_r    <= STATUS_RESET;
         mask_r      <= MASK_RESET;
         irq_r       <= 1'b0;
         nmi_req_r   <= 1'b0;
         reset_req_r <= 1'b0;
      end else begin
         status_r    <= status_nxt;
         mask_r      <= mask_nxt;
         irq_r       <= |(status_nxt & mask_nxt);
         nmi_req_r   <= err_evt && !active_r.error_response_select;
         reset_req_r <= err_evt && active_r.error_response_select;
      end
   end

   // timing figures registered so outputs leave straight from flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         interval_r <= {CNT_W{1'b0}};
         window_r   <= {CNT_W{1'b0}};
      end else begin
         interval_r <= interval_w;
         window_r   <= window_w;
      end
   end

   assign awready        = awready_r;
   assign wready         = wready_r;
   assign bvalid         = bvalid_r;
   assign bresp          = bresp_r;
   assign arready        = arready_r;
   assign rvalid         = rvalid_r;
   assign rdata          = rdata_r;
   assign rresp          = rresp_r;
   assign active_mode    = active_r;
   assign interval_count = interval_r;
   assign window_count   = window_r;
   assign nmi_req        = nmi_req_r;
   assign reset_req      = reset_req_r;
   assign irq            = irq_r;

   // checks next to the logic above

   property p_first_write;
      @(posedge aclk) disable iff (!aresetn)
      (wr_mode && phase_r == ST_OPEN) |=> (mode_r == $past(wr_val) && phase_r != ST_OPEN);
   endproperty
   a_first_write: assert property (p_first_write) else $error("first mode write not stored");

   property p_second_locked;
      @(posedge aclk) disable iff (!aresetn)
      (wr_mode && phase_r == ST_SET && !wdt_trigger) |=> $stable(mode_r);
   endproperty
   a_second_locked: assert property (p_second_locked) else $error("mode changed by second write");

   property p_apply_at_trigger;
      @(posedge aclk) disable iff (!aresetn)
      wdt_trigger |=> (active_r == mode_r && phase_r == ST_RUN);
   endproperty
   a_apply_at_trigger: assert property (p_apply_at_trigger) else $error("mode not applied at trigger");

   property p_hold_no_trigger;
      @(posedge aclk) disable iff (!aresetn)
      !wdt_trigger |=> $stable(active_r);
   endproperty
   a_hold_no_trigger: assert property (p_hold_no_trigger) else $error("running mode changed early");

   property p_trigger_seen;
      @(posedge aclk) disable iff (!aresetn)
      wdt_trigger |=> status_r[ST_TRIGGER];
   endproperty
   a_trigger_seen: assert property (p_trigger_seen) else $error("trigger not recorded");

   sequence s_bad_write;
      wr_mode && locked && differs;
   endsequence
   sequence s_err_flag;
      status_r[ST_MODE_ERR] && $stable(mode_r);
   endsequence
   property p_change_err;
      @(posedge aclk) disable iff (!aresetn)
      s_bad_write |=> s_err_flag;
   endproperty
   a_change_err: assert property (p_change_err) else $error("changing write raised no error");

   property p_same_silent;
      @(posedge aclk) disable iff (!aresetn)
      (wr_mode && locked && !differs && !status_r[ST_MODE_ERR] && !(nmi_req_r || reset_req_r)
       && !wdt_overflow) |=> (!status_r[ST_MODE_ERR] && !nmi_req_r && !reset_req_r);
   endproperty
   a_same_silent: assert property (p_same_silent) else $error("identical write raised error");

   property p_byte_only;
      @(posedge aclk) disable iff (!aresetn)
      (do_wr && hit_mode && !byte_ok) |=> (bvalid_r && bresp_r == RESP_SLVERR && $stable(mode_r));
   endproperty
   a_byte_only: assert property (p_byte_only) else $error("wide mode write accepted");

   // gated on aresetn: the timing figures still hold their reset zero one cycle after release
   property p_interval;
      @(posedge aclk) disable iff (!aresetn)
      (aresetn && active_r.overflow_interval_select == 3'h0) |=> interval_r == 17'h00200;
   endproperty
   a_interval: assert property (p_interval) else $error("shortest interval not 2^9");

   property p_nmi_route;
      @(posedge aclk) disable iff (!aresetn)
      (err_evt && !active_r.error_response_select) |=> (nmi_req_r && !reset_req_r);
   endproperty
   a_nmi_route: assert property (p_nmi_route) else $error("error not sent as interrupt");

   property p_reset_route;
      @(posedge aclk) disable iff (!aresetn)
      (err_evt && active_r.error_response_select) |=> (reset_req_r && !nmi_req_r);
   endproperty
   a_reset_route: assert property (p_reset_route) else $error("error not sent as reset");

   sequence s_full_window;
      (active_r.window_size_select == 2'h3) ##1 $stable(active_r);
   endsequence
   property p_window;
      @(posedge aclk) disable iff (!aresetn)
      s_full_window |-> window_r == interval_r;
   endproperty
   a_window: assert property (p_window) else $error("full window differs from interval");

   property p_reserved;
      @(posedge aclk) disable iff (!aresetn)
      (ar_hs && rd_mode) |=> (rvalid_r && rdata_r[7] == 1'b0 && rdata_r[3] == MODE_RESET[3]);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved mode bits read wrong");

endmodule

/* File: dv/tb.sv */
// self-checking testbench for the watchdog mode control block
`timescale 1ns/10ps
module tb
   import wdt_mode_pkg::*;
;
   logic             aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic             arvalid, arready, rvalid, rready, wdt_trigger, wdt_overflow, nmi_req, reset_req, irq;
   logic [31:0]      awaddr, wdata, araddr, rdata, rd;
   logic [3:0]       wstrb;
   logic [2:0]       awprot, arprot;
   logic [1:0]       bresp, rresp, resp;
   logic [CNT_W-1:0] interval_count, window_count;
   logic [7:0]       v;
   mode_s            active_mode;
   int               num_errors, cmp_count, nmi_cnt, rst_cnt, n0, r0;

   wdt_mode_ctrl wdt_mode_ctrl_inst (
      .aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .wdt_trigger, .wdt_overflow, .active_mode, .interval_count, .window_count,
      .nmi_req, .reset_req, .irq
   );

   // 250 MHz clock
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   // error pulses are one cycle wide, so they are counted here rather than polled
   always @(posedge aclk) begin
      if (nmi_req === 1'b1) nmi_cnt++;
      if (reset_req === 1'b1) rst_cnt++;
   end

   task automatic results();
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic hang(input string name);
      num_errors++;
      $display("[ERR] %s expected answer seen timeout", name);
      results();
   endtask

   // write: address and data offered together, each released when taken
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
      int   n;
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 200; n++) begin
         @(posedge aclk);
         if (!aw_ok && awready) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
         if (bvalid) begin
            resp = bresp;
            bready <= 1'b0;
            break;
         end
      end
      if (n == 200) hang("write");
   endtask

   task automatic axi_rd(input logic [31:0] a);
      int   n;
      logic ar_ok;
      ar_ok = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 200; n++) begin
         @(posedge aclk);
         if (!ar_ok && arready) begin
            ar_ok = 1'b1;
            arvalid <= 1'b0;
         end
         if (rvalid) begin
            rd = rdata;
            resp = rresp;
            rready <= 1'b0;
            break;
         end
      end
      if (n == 200) hang("read");
   endtask

   task automatic pulse(input bit trig);
      @(posedge aclk);
      if (trig) wdt_trigger <= 1'b1;
      else wdt_overflow <= 1'b1;
      @(posedge aclk);
      wdt_trigger <= 1'b0;
      wdt_overflow <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask

   task automatic rst();
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
   endtask

   // readback: bit 7 reads zero, bit 3 keeps its reset one
   function automatic logic [31:0] rb(input logic [7:0] m);
      return {24'h000000, 1'b0, m[6:4], 1'b1, m[2:0]};
   endfunction

   function automatic logic [31:0] ivl(input logic [7:0] m);
      return 32'h00000001 << (9 + m[6:4]);
   endfunction

   function automatic logic [31:0] win(input logic [7:0] m);
      return (ivl(m) * (m[1:0] + 1)) / 4;
   endfunction

   // each pass sets one interval code, so all eight codes, windows and responses are seen
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, wdt_trigger, wdt_overflow} = 8'h00;
      {awaddr, wdata, araddr, wstrb, awprot, arprot} = 106'h0;
      void'($urandom(32'hE3A3));
      for (int i = 0; i < 8; i++) begin
         rst();
         v = 8'($urandom);
         v[6:4] = i[2:0];
         v[1:0] = i[1:0];
         v[2] = i[0] ^ i[2];
         if (i == 0) begin
            axi_rd(MODE_ADDR);
            chk("mode reset", 32'h0000000F, rd);
            axi_rd(32'h4000_0800);
            chk("unmapped rresp", 32'(RESP_SLVERR), 32'(resp));
            axi_wr(32'h4000_0800, 32'hFFFF_FFFF, 4'hF);
            chk("unmapped bresp", 32'(RESP_SLVERR), 32'(resp));
         end
         axi_wr(MODE_ADDR, {24'($urandom), v ^ 8'h30}, 4'($urandom) | 4'h2);
         chk("wide write bresp", 32'(RESP_SLVERR), 32'(resp));
         axi_rd(MODE_ADDR);
         chk("mode after wide write", 32'h0000000F, rd);
         axi_wr(MODE_ADDR, {24'h000000, v}, BYTE0_STRB);
         chk("first write bresp", 32'(RESP_OKAY), 32'(resp));
         axi_rd(MODE_ADDR);
         chk("mode readback", rb(v), rd);
         // a second, differing write before the first trigger is refused and flagged
         if (i[0]) begin
            r0 = rst_cnt;
            axi_wr(MODE_ADDR, {24'h000000, v ^ 8'h41}, BYTE0_STRB);
            repeat (2) @(posedge aclk);
            chk("early rewrite reset", 32'(r0 + int'(MODE_RESET[2])), 32'(rst_cnt));
            axi_rd(MODE_ADDR);
            chk("early rewrite kept", rb(v), rd);
         end
         chk("active before trigger", 32'(MODE_RESET), 32'(active_mode));
         pulse(1'b1);
         chk("active after trigger", rb(v), 32'(active_mode));
         chk("interval", ivl(v), 32'(interval_count));
         chk("window", win(v), 32'(window_count));
         // clear the trigger-seen flag so only the mode error is left to see
         axi_wr(STATUS_ADDR, 32'h7, 4'hF);
         axi_wr(MASK_ADDR, 32'h1, 4'hF);
         n0 = nmi_cnt;
         r0 = rst_cnt;
         axi_wr(MODE_ADDR, {24'h000000, v}, BYTE0_STRB);
         repeat (2) @(posedge aclk);
         chk("same value irq", 32'h0, 32'(irq));
         chk("same value pulses", 32'(n0 + r0), 32'(nmi_cnt + rst_cnt));
         axi_wr(MODE_ADDR, {24'h000000, v ^ 8'h10}, BYTE0_STRB);
         repeat (2) @(posedge aclk);
         chk("change irq", 32'h1, 32'(irq));
         chk("change nmi", 32'(n0 + (v[2] ? 0 : 1)), 32'(nmi_cnt));
         chk("change reset", 32'(r0 + (v[2] ? 1 : 0)), 32'(rst_cnt));
         axi_rd(MODE_ADDR);
         chk("mode kept", rb(v), rd);
         axi_rd(STATUS_ADDR);
         chk("status", 32'h1, rd);
         axi_rd(STATE_ADDR);
         chk("state", (rb(v) << 8) | 32'h3, rd);
         axi_wr(STATUS_ADDR, 32'h1, 4'hF);
         repeat (2) @(posedge aclk);
         chk("irq cleared", 32'h0, 32'(irq));
         pulse(1'b0);
         chk("ovf nmi", 32'(n0 + (v[2] ? 0 : 2)), 32'(nmi_cnt));
         chk("ovf reset", 32'(r0 + (v[2] ? 2 : 0)), 32'(rst_cnt));
         chk("ovf masked irq", 32'h0, 32'(irq));
         axi_wr(MASK_ADDR, 32'h7, 4'hF);
         repeat (2) @(posedge aclk);
         chk("ovf unmasked irq", 32'h1, 32'(irq));
      end
      results();
   end
endmodule
